/* File: inc/bbs_pkg.sv */
// Constants and types shared by the branch and bit-set execution block.
// Functional notes
// (RULE1) Relative jump: opcode 11010, signed 11-bit offset.
// (RULE2) Jump target is incremented address plus 2n.
// (RULE3) Relative jump takes two cycles, second flushes.
// (RULE4) Set file bit forces one bit, others kept.
// (RULE5) Set file bit: 1000, bit, bank mode, address.
// (RULE6) Bank mode 0 selects the access bank.
// (RULE7) Bank mode 1 uses bank select plus address.
// (RULE8) Extended set, mode 0, address <= 5Fh: indexed.
// (RULE9) Bit set: read Q2, modify Q3, write Q4; the code forms the new byte in Q2 and raises the write strobe in Q3.
// (RULE10) Neither instruction alters any status flag.
package bbs_pkg;

	localparam int PROG_W = 21;
	localparam int ADDR_W = 12;
	localparam int INSN_W = 16;

	// ----------------------------------------------------------------
	// Instruction fields
	// ----------------------------------------------------------------
	localparam logic [4:0] JUMP_OPC     = 5'h1A;
	localparam int         JUMP_OPC_LSB = 11;
	localparam int         JUMP_OFS_W   = 11;
	localparam logic [3:0] SETB_OPC     = 4'h8;
	localparam int         SETB_OPC_LSB = 12;
	localparam int         SETB_BIT_LSB = 9;
	localparam int         SETB_MODE    = 8;
	localparam int         SETB_FILE_W  = 8;

	// ----------------------------------------------------------------
	// Data address map
	// ----------------------------------------------------------------
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [7:0] INDEX_LIMIT  = 8'h5F;
	localparam logic [3:0] ACCESS_HIGH  = 4'hF;
	localparam logic [3:0] ACCESS_LOW   = 4'h0;

	// ----------------------------------------------------------------
	// Reset values and steps
	// ----------------------------------------------------------------
	localparam logic [PROG_W-1:0] PROG_RESET = 21'h000000;
	localparam logic [PROG_W-1:0] PROG_STEP  = 21'h000002;
	localparam logic [INSN_W-1:0] INSN_NOP   = 16'h0000;

	typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} bbs_phase_t;
	typedef enum logic {ST_RUN, ST_FLUSH} bbs_state_t;

endpackage : bbs_pkg

/* File: inc/bbs_addr_if.sv */
// Interface carrying an operand address request to the address resolver.
`timescale 1ns/100ps
`default_nettype none
interface bbs_addr_if;
	logic [7:0]                 fileAddr;
	logic                       bankMode;
	logic [3:0]                 bankSel;
	logic                       extEnable;
	logic [bbs_pkg::ADDR_W-1:0] indexBase;
	logic [bbs_pkg::ADDR_W-1:0] dataAddr;

	modport req (output fileAddr, output bankMode, output bankSel, output extEnable,
		output indexBase, input dataAddr);
	modport rsp (input fileAddr, input bankMode, input bankSel, input extEnable,
		input indexBase, output dataAddr);
endinterface : bbs_addr_if
`default_nettype wire

/* File: core/bbs_addr_resolve.sv */
// Resolves the file operand of a bit-set into a full data address.
`timescale 1ns/100ps
`default_nettype none
module bbs_addr_resolve (
	bbs_addr_if.rsp ai
);
	always_comb begin
		if (ai.bankMode) begin
			ai.dataAddr = {ai.bankSel, ai.fileAddr}; // [RULE7]
		end else if (ai.extEnable && ai.fileAddr <= bbs_pkg::INDEX_LIMIT) begin
			// Indexed literal offset: the file field is an offset from the index base.
			ai.dataAddr = ai.indexBase + {4'h0, ai.fileAddr}; // [RULE8]
		end else if (ai.fileAddr < bbs_pkg::ACCESS_SPLIT) begin
			ai.dataAddr = {bbs_pkg::ACCESS_LOW, ai.fileAddr}; // [RULE6]
		end else begin
			ai.dataAddr = {bbs_pkg::ACCESS_HIGH, ai.fileAddr}; // [RULE6]
		end
	end
endmodule : bbs_addr_resolve
`default_nettype wire

/* File: core/bbs_exec.sv */
// Executes the unconditional relative jump and the set-file-bit instructions.
`timescale 1ns/100ps
`default_nettype none
module bbs_exec (
	input  wire logic                       ref_clk,
	input  wire logic                       arst_n,
	input  wire logic [bbs_pkg::INSN_W-1:0] instrWord,
	input  wire logic                       instrValid,
	output logic                            instrReady,
	input  wire logic [3:0]                 bankSelect,
	input  wire logic                       extEnable,
	input  wire logic [bbs_pkg::ADDR_W-1:0] indexBase,
	output logic [bbs_pkg::PROG_W-1:0]      programCounter,
	output logic [bbs_pkg::ADDR_W-1:0]      dataAddr,
	output logic                            dataRead,
	input  wire logic [7:0]                 dataRdData,
	output logic                            dataWrite,
	output logic [7:0]                      dataWrData,
	output logic                            statusWrite,
	output logic                            flushCycle,
	output logic [1:0]                      phase
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rstMeta;
	logic rstSync;
	logic next_rstMeta;
	logic next_rstSync;

	// Reset is taken at once but let go only on a clock edge, two flops later,
	// so no register of the block leaves reset a cycle ahead of its neighbours.
	// The price is two idle clocks after every release.
	always_comb begin
		next_rstMeta = 1'b1;
		next_rstSync = rstMeta;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end else begin
			rstMeta <= next_rstMeta;
			rstSync <= next_rstSync;
		end
	end

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic isJump(input logic [bbs_pkg::INSN_W-1:0] w);
		isJump = (w[bbs_pkg::INSN_W-1:bbs_pkg::JUMP_OPC_LSB] == bbs_pkg::JUMP_OPC); // [RULE1]
	endfunction : isJump

	function automatic logic isSetBit(input logic [bbs_pkg::INSN_W-1:0] w);
		isSetBit = (w[bbs_pkg::INSN_W-1:bbs_pkg::SETB_OPC_LSB] == bbs_pkg::SETB_OPC); // [RULE5]
	endfunction : isSetBit

	// ----------------------------------------------------------------
	// Sequencer state
	// ----------------------------------------------------------------
	bbs_pkg::bbs_phase_t          phaseQ;
	bbs_pkg::bbs_phase_t          next_phaseQ;
	bbs_pkg::bbs_state_t          state;
	bbs_pkg::bbs_state_t          next_state;
	logic [bbs_pkg::INSN_W-1:0]   cur;
	logic [bbs_pkg::INSN_W-1:0]   next_cur;
	logic                         curValid;
	logic                         next_curValid;
	logic [bbs_pkg::PROG_W-1:0]   next_programCounter;
	logic [bbs_pkg::ADDR_W-1:0]   next_dataAddr;
	logic                         next_dataRead;
	logic                         next_dataWrite;
	logic [7:0]                   next_dataWrData;
	logic [bbs_pkg::ADDR_W-1:0]   resolvedAddr;
	logic [bbs_pkg::PROG_W-1:0]   jumpTarget;
	logic [2:0]                   bitSel;
	logic                         take;
	logic                         curJump;
	logic                         curSetBit;

	bbs_addr_if ai ();

	assign ai.fileAddr  = cur[bbs_pkg::SETB_FILE_W-1:0];
	assign ai.bankMode  = cur[bbs_pkg::SETB_MODE];
	assign ai.bankSel   = bankSelect;
	assign ai.extEnable = extEnable;
	assign ai.indexBase = indexBase;
	assign resolvedAddr = ai.dataAddr;

	bbs_addr_resolve u_resolve (
		.ai (ai.rsp)
	);

	assign curJump   = curValid && isJump(cur);
	assign curSetBit = curValid && isSetBit(cur);
	assign bitSel    = cur[bbs_pkg::SETB_BIT_LSB +: 3];

	// The counter already holds the incremented fetch address, so only 2n is added.
	assign jumpTarget = programCounter + {{(bbs_pkg::PROG_W-bbs_pkg::JUMP_OFS_W-1)
		{cur[bbs_pkg::JUMP_OFS_W-1]}}, cur[bbs_pkg::JUMP_OFS_W-1:0], 1'b0}; // [RULE2]

	// A fetch is offered in Q4 except while a jump is finishing, since that
	// slot belongs to the old, already discarded, next instruction.
	assign instrReady = rstSync && (phaseQ == bbs_pkg::PH_Q4) &&
		!(state == bbs_pkg::ST_RUN && curJump); // [RULE3]
	assign take = instrReady && instrValid;

	// The phase ring runs Q1 to Q4 without pause; a word is taken only at the
	// edge that closes Q4, so every instruction cycle is exactly four clocks.
	// A word offered while the slot is closed stays outside and is not lost.
	always_comb begin
		next_phaseQ         = phaseQ;
		next_state          = state;
		next_cur            = cur;
		next_curValid       = curValid;
		next_programCounter = programCounter;
		unique case (phaseQ)
			bbs_pkg::PH_Q1: begin
				next_phaseQ = bbs_pkg::PH_Q2;
			end
			bbs_pkg::PH_Q2: begin
				next_phaseQ = bbs_pkg::PH_Q3;
			end
			bbs_pkg::PH_Q3: begin
				next_phaseQ = bbs_pkg::PH_Q4;
			end
			bbs_pkg::PH_Q4: begin
				next_phaseQ = bbs_pkg::PH_Q1;
				if (state == bbs_pkg::ST_RUN && curJump) begin
					next_programCounter = jumpTarget; // [RULE2]
					next_state          = bbs_pkg::ST_FLUSH; // [RULE3]
					next_curValid       = 1'b0;
				end else begin
					next_state = bbs_pkg::ST_RUN;
					if (take) begin
						next_cur            = instrWord;
						next_curValid       = 1'b1;
						next_programCounter = programCounter + bbs_pkg::PROG_STEP;
					end else begin
						next_cur      = bbs_pkg::INSN_NOP;
						next_curValid = 1'b0;
					end
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			phaseQ         <= bbs_pkg::PH_Q1;
			state          <= bbs_pkg::ST_RUN;
			cur            <= bbs_pkg::INSN_NOP;
			curValid       <= 1'b0;
			programCounter <= bbs_pkg::PROG_RESET;
		end else if (!rstSync) begin
			phaseQ         <= bbs_pkg::PH_Q1;
			state          <= bbs_pkg::ST_RUN;
			cur            <= bbs_pkg::INSN_NOP;
			curValid       <= 1'b0;
			programCounter <= bbs_pkg::PROG_RESET;
		end else begin
			phaseQ         <= next_phaseQ;
			state          <= next_state;
			cur            <= next_cur;
			curValid       <= next_curValid;
			programCounter <= next_programCounter;
		end
	end

	// ----------------------------------------------------------------
	// Data port
	// ----------------------------------------------------------------
	// The strobes are registered, so the read stands in Q2 and the write in Q3;
	// the memory takes the write at the edge that opens Q4. The read data must
	// therefore be ready before the edge that closes Q2.
	always_comb begin
		next_dataAddr   = dataAddr;
		next_dataRead   = 1'b0;
		next_dataWrite  = 1'b0;
		next_dataWrData = dataWrData;
		if (curSetBit && phaseQ == bbs_pkg::PH_Q1) begin
			next_dataAddr = resolvedAddr;
			next_dataRead = 1'b1; // [RULE9]
		end
		if (curSetBit && phaseQ == bbs_pkg::PH_Q2) begin
			next_dataWrData = dataRdData | (8'h01 << bitSel); // [RULE4] [RULE9]
			next_dataWrite  = 1'b1; // [RULE9]
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			dataAddr   <= '0;
			dataRead   <= 1'b0;
			dataWrite  <= 1'b0;
			dataWrData <= 8'h00;
		end else if (!rstSync) begin
			dataAddr   <= '0;
			dataRead   <= 1'b0;
			dataWrite  <= 1'b0;
			dataWrData <= 8'h00;
		end else begin
			dataAddr   <= next_dataAddr;
			dataRead   <= next_dataRead;
			dataWrite  <= next_dataWrite;
			dataWrData <= next_dataWrData;
		end
	end

	// ----------------------------------------------------------------
	// Observation outputs
	// ----------------------------------------------------------------
	// Neither instruction has an arithmetic result, so the flags are never written.
	assign statusWrite = 1'b0; // [RULE10]
	assign flushCycle  = (state == bbs_pkg::ST_FLUSH); // [RULE3]
	assign phase       = phaseQ;

endmodule : bbs_exec
`default_nettype wire

/* File: tb/bbs_exec_sva.sv */
// Concurrent checks on the ports of the jump and bit-set execution block.
`timescale 1ns/100ps
`default_nettype none
module bbs_exec_sva (
	input wire logic                       ref_clk,
	input wire logic                       arst_n,
	input wire logic [bbs_pkg::INSN_W-1:0] instrWord,
	input wire logic                       instrValid,
	input wire logic                       instrReady,
	input wire logic [3:0]                 bankSelect,
	input wire logic                       extEnable,
	input wire logic [bbs_pkg::ADDR_W-1:0] indexBase,
	input wire logic [bbs_pkg::PROG_W-1:0] programCounter,
	input wire logic [bbs_pkg::ADDR_W-1:0] dataAddr,
	input wire logic                       dataRead,
	input wire logic [7:0]                 dataRdData,
	input wire logic                       dataWrite,
	input wire logic [7:0]                 dataWrData,
	input wire logic                       statusWrite,
	input wire logic                       flushCycle,
	input wire logic [1:0]                 phase
);
	logic                     take;
	logic                     isJump;
	logic                     isSet;
	logic [7:0]               fileAddr;
	logic [bbs_pkg::PROG_W-1:0] jumpOfs;
	logic [2:0]               setBitNum;
	assign take     = instrReady && instrValid;
	assign isJump   = take && (instrWord[15:11] == 5'h1A);
	assign isSet    = take && (instrWord[15:12] == 4'h8);
	assign fileAddr = instrWord[7:0];
	assign jumpOfs  = {{9{instrWord[10]}}, instrWord[10:0], 1'b0};
	always_ff @(posedge ref_clk) begin
		if (isSet) begin
			setBitNum <= instrWord[11:9];
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	a_status_untouched: assert property (statusWrite == 1'b0)
		else $error("status write enable raised");
	a_read_in_q2: assert property (dataRead |-> phase == 2'h1)
		else $error("read strobe outside second phase");
	a_write_after_read: assert property (dataRead |=> dataWrite && !dataRead)
		else $error("write strobe does not follow read");
	a_one_bit_set: assert property (dataWrite |-> (dataWrData & $past(dataRdData))
		== $past(dataRdData) && $countones(dataWrData ^ $past(dataRdData)) <= 1)
		else $error("write data changes more than one set bit");
	a_named_bit_set: assert property (dataWrite |-> dataWrData[setBitNum] == 1'b1)
		else $error("named bit not set in write data");
	a_flush_no_data: assert property (flushCycle |-> !dataRead && !dataWrite)
		else $error("data strobe during jump flush cycle");
	a_ready_in_q4: assert property (instrReady |-> phase == 2'h3)
		else $error("fetch slot outside fourth phase");
	a_pc_step: assert property (take |=> programCounter == $past(programCounter) + 21'h2)
		else $error("program counter did not step on fetch");
	a_jump_flush: assert property (isJump |=> ##3 !instrReady ##1 flushCycle [*4])
		else $error("jump not followed by a flush cycle");
	a_jump_target: assert property (isJump |=> ##3 1'b1 ##1
		programCounter == $past(programCounter, 4) + $past(jumpOfs, 5))
		else $error("jump target wrong");
	a_bank_addr: assert property (isSet && instrWord[8] |=> ##1 dataRead &&
		dataAddr == {bankSelect, $past(fileAddr, 2)})
		else $error("banked address wrong");
	a_access_addr: assert property (isSet && !instrWord[8] && !(extEnable && fileAddr <= 8'h5F)
		|=> ##1 dataAddr == {($past(fileAddr, 2) >= 8'h60) ? 4'hF : 4'h0, $past(fileAddr, 2)})
		else $error("access bank address wrong");
	a_indexed_addr: assert property (isSet && !instrWord[8] && extEnable && fileAddr <= 8'h5F
		|=> ##1 dataAddr == indexBase + {4'h0, $past(fileAddr, 2)})
		else $error("indexed address wrong");
endmodule : bbs_exec_sva
`default_nettype wire

/* File: tb/bbs_exec_tb_top.sv */
// Self-checking bench for the jump and bit-set execution block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin nMismatch++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module bbs_exec_tb_top;
	logic        ref_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [15:0] instrWord = 16'h0000;
	logic        instrValid = 1'b0;
	logic [3:0]  bankSelect = 4'h0;
	logic        extEnable = 1'b0;
	logic [11:0] indexBase = 12'h000;
	logic [7:0]  dataRdData = 8'h00;
	logic        instrReady, dataRead, dataWrite, statusWrite, flushCycle;
	logic [20:0] programCounter, pcModel;
	logic [11:0] dataAddr;
	logic [7:0]  dataWrData;
	logic [1:0]  phase;
	logic [21:0] expQ[$];
	logic [21:0] note;
	logic [31:0] r;
	logic        prevFlush = 1'b0;
	int          nMismatch = 0, checked = 0, cycles = 0;
	logic [15:0] edgeWords [8] = '{16'hD400, 16'hD3FF, 16'h805F, 16'h8E60,
		16'h81FF, 16'h8000, 16'h0000, 16'hD7FF};
	bbs_exec dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .instrWord(instrWord),
		.instrValid(instrValid), .instrReady(instrReady), .bankSelect(bankSelect),
		.extEnable(extEnable), .indexBase(indexBase), .programCounter(programCounter),
		.dataAddr(dataAddr), .dataRead(dataRead), .dataRdData(dataRdData),
		.dataWrite(dataWrite), .dataWrData(dataWrData), .statusWrite(statusWrite),
		.flushCycle(flushCycle), .phase(phase));
	initial forever #5 ref_clk = ~ref_clk;
	task complete_run();
		if (nMismatch == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run
	// Every open slot gets a word, so the program counter model steps on each call.
	task issue(input logic [15:0] w, input logic [7:0] rd);
		logic [7:0]  f;
		logic [11:0] a;
		do @(negedge ref_clk); while (instrReady !== 1'b1);
		instrWord = w;
		instrValid = 1'b1;
		dataRdData = rd;
		bankSelect = 4'($urandom);
		extEnable = 1'($urandom);
		indexBase = 12'($urandom);
		pcModel = pcModel + 21'h2;
		f = w[7:0];
		if (w[15:11] == 5'h1A) begin
			pcModel = pcModel + {{9{w[10]}}, w[10:0], 1'b0};
			expQ.push_back({1'b1, pcModel});
		end else if (w[15:12] == 4'h8) begin
			a = w[8] ? {bankSelect, f} : (extEnable && f <= 8'h5F) ? indexBase + {4'h0, f}
				: {(f >= 8'h60) ? 4'hF : 4'h0, f};
			expQ.push_back({2'b00, a, rd | (8'h01 << w[11:9])});
		end
	endtask : issue
	always @(posedge ref_clk) begin
		cycles++;
		prevFlush <= flushCycle;
		if (cycles == 3000) begin
			nMismatch++;
			complete_run();
		end
		if (dataWrite === 1'b1) begin
			note = expQ.pop_front();
			`CHK({2'b00, dataAddr, dataWrData}, note)
		end
		if (flushCycle === 1'b1 && prevFlush === 1'b0) begin
			note = expQ.pop_front();
			`CHK({1'b1, programCounter}, note)
		end
	end
	initial begin
		void'($urandom(43292));
		pcModel = 21'h0;
		repeat (10) @(negedge ref_clk);
		arst_n = 1'b1;
		foreach (edgeWords[i]) issue(edgeWords[i], 8'h5A);
		repeat (60) begin
			r = $urandom;
			issue(r[1:0] == 2'h0 ? {5'h1A, r[12:2]} : r[1:0] == 2'h3 ? 16'h0000
				: {4'h8, r[15:4]}, r[23:16]);
		end
		@(negedge ref_clk);
		instrValid = 1'b0;
		repeat (12) @(negedge ref_clk);
		`CHK(expQ.size(), 0)
		complete_run();
	end
endmodule : bbs_exec_tb_top
bind bbs_exec bbs_exec_sva chk_u (.ref_clk(ref_clk), .arst_n(arst_n), .instrWord(instrWord),
	.instrValid(instrValid), .instrReady(instrReady), .bankSelect(bankSelect),
	.extEnable(extEnable), .indexBase(indexBase), .programCounter(programCounter),
	.dataAddr(dataAddr), .dataRead(dataRead), .dataRdData(dataRdData),
	.dataWrite(dataWrite), .dataWrData(dataWrData), .statusWrite(statusWrite),
	.flushCycle(flushCycle), .phase(phase));
`default_nettype wire
